// [verilog/fspr_pkg.sv]
/*
  Constants and types for the flash status and protection register block.
  Assumes a 2 MB array, 256-byte pages and SPI mode 0 or 3 framing.
*/
package fspr_pkg;
  // ==========================================================================
  // Instruction codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR_LO = 8'h05;
  localparam logic [7:0] CMD_RDSR_HI = 8'h35;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_QPROG = 8'h32;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLK32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLK64_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] CMD_SECR_ERASE = 8'h44;
  localparam logic [7:0] CMD_SECR_PROG = 8'h42;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  // ==========================================================================
  // Frame lengths in link bits
  localparam logic [5:0] BITS_OP = 6'h08;
  localparam logic [5:0] BITS_OP_LAST = 6'h07;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_ADDR_LAST = 6'h1F;
  localparam logic [5:0] BITS_WRSR1 = 6'h10;
  localparam logic [5:0] BITS_WRSR2 = 6'h18;
  localparam logic [5:0] BITS_PROG_MIN = 6'h28;
  localparam logic [5:0] BITS_SAT = 6'h3F;
  localparam logic [2:0] BIT_MSB = 3'h7;
  // ==========================================================================
  // Array geometry
  localparam int ADDR_W = 21;
  localparam logic [21:0] FLASH_TOP = 22'h200000;
  localparam logic [21:0] SECT_BYTES = 22'h001000;
  localparam logic [21:0] BLK_BYTES = 22'h010000;
  localparam logic [20:0] MASK_PAGE = 21'h0000FF;
  localparam logic [20:0] MASK_SECT = 21'h000FFF;
  localparam logic [20:0] MASK_BLK32 = 21'h007FFF;
  localparam logic [20:0] MASK_BLK64 = 21'h00FFFF;
  localparam logic [2:0] RANGE_SECT_MAX = 3'h4;
  localparam int SECR_IDX_LSB = 12;
  // ==========================================================================
  // Pin sampling
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_B = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_WP_B = 3;
  localparam int PIN_N = 4;
  localparam logic [PIN_N-1:0] PIN_IDLE = 4'hB;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_SUSP = 2'h3
  } fspr_state_e;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PROG = 4'h1,
    OP_QPROG = 4'h2,
    OP_SECT_ERASE = 4'h3,
    OP_BLK32_ERASE = 4'h4,
    OP_BLK64_ERASE = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_SECR_ERASE = 4'h7,
    OP_SECR_PROG = 4'h8,
    OP_SR_WRITE = 4'h9,
    OP_SUSPEND = 4'hA,
    OP_RESUME = 4'hB
  } fspr_op_e;

  // Non-volatile image, S14..S2 without volatile bits
  typedef struct packed {
    logic complement_protect;
    logic [2:0] security_lock;
    logic quad_enable_bit;
    logic status_protect_hi;
    logic status_protect_lo;
    logic sector_block_select;
    logic top_bottom_select;
    logic [2:0] range_bits;
  } fspr_nv_s;

  typedef struct packed {
    fspr_op_e kind;
    logic [23:0] addr;
  } fspr_op_s;
endpackage : fspr_pkg

// [verilog/fspr_status_protect.sv]
/*
  Status and protection register logic of a serial flash, reached over the
  SPI pins. Assumes an external array engine that runs each started
  operation and pulses op_done_i when it ends, and a store that keeps the
  non-volatile image across power cycles.
*/
// What this block does
// - Busy reads one while program, erase or status write runs.
// - While busy only status reads and suspend are honoured.
// - Busy drops to zero when the running operation completes.
// - Write enable instruction sets the write enable latch.
// - Latch clears at power-up, write disable and completed write operations.
// - Three range bits are non-volatile, written by status write, default zero.
// - Program and erase touching the protected region are refused.
// - Top/bottom select anchors the range at top when zero, bottom when one.
// - Sector/block select picks 4KB units when set, 64KB when clear.
// - Complement bit inverts protected and unprotected regions.
// - Two protect-mode bits with write-protect pin choose status write guarding.
// - Mode 00 ignores the pin; writes accepted whenever the latch is set.
// - Mode 01 with write-protect pin low locks the status register unless quad enable is set.
// - Mode 01 with pin high accepts writes once the latch is set.
// - Mode 10 refuses writes until power cycle, which restores mode 00.
// - Mode 11 protects the status register permanently.
// - Suspend sets the suspend flag; resume or power cycle clears it.
// - Three security lock bits set individually, never cleared again.
// - Quad enable bit frees write-protect and hold pins as quad lines.
// - Quad instructions accepted only while quad enable is set.
`timescale 1ns/1ps
module fspr_status_protect (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic di_i,
  input wire logic wp_b_i,
  input wire fspr_pkg::fspr_nv_s nv_image_i,
  input wire logic op_done_i,
  output logic do_o,
  output logic do_oe_b_o,
  output logic busy_o,
  output logic quad_lines_o,
  output fspr_pkg::fspr_nv_s nv_image_o,
  output logic op_valid_o,
  output fspr_pkg::fspr_op_s op_o
);
  import fspr_pkg::*;

  // ==========================================================================
  // Reset release and pin sampling
  logic rst_q1_reg;
  logic rst_n;
  logic [PIN_N-1:0] pin_s1_reg;
  logic [PIN_N-1:0] pin_s2_reg;
  logic [PIN_N-1:0] pin_s3_reg;
  logic [PIN_N-1:0] pin_f_reg;
  logic sclk_prev_reg;
  logic cs_prev_reg;

  // Two-stage reset release
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_n <= rst_q1_reg;
    end
  end

  // Four flops per pin, value taken once stages two and three agree
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_reg[g] <= PIN_IDLE[g];
        pin_s2_reg[g] <= PIN_IDLE[g];
        pin_s3_reg[g] <= PIN_IDLE[g];
        pin_f_reg[g] <= PIN_IDLE[g];
      end else begin
        pin_s1_reg[g] <= (g == PIN_SCLK) ? sclk_i : (g == PIN_CS_B) ? cs_b_i :
                         (g == PIN_DI) ? di_i : wp_b_i;
        pin_s2_reg[g] <= pin_s1_reg[g];
        pin_s3_reg[g] <= pin_s2_reg[g];
        if (pin_s2_reg[g] == pin_s3_reg[g]) begin
          pin_f_reg[g] <= pin_s3_reg[g];
        end
      end
    end
  end

  // Edge history of clock and select
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_reg <= PIN_IDLE[PIN_SCLK];
      cs_prev_reg <= PIN_IDLE[PIN_CS_B];
    end else begin
      sclk_prev_reg <= pin_f_reg[PIN_SCLK];
      cs_prev_reg <= pin_f_reg[PIN_CS_B];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;
  assign sclk_rise = pin_f_reg[PIN_SCLK] & ~sclk_prev_reg;
  assign sclk_fall = ~pin_f_reg[PIN_SCLK] & sclk_prev_reg;
  assign cs_fall = ~pin_f_reg[PIN_CS_B] & cs_prev_reg;
  assign cs_rise = pin_f_reg[PIN_CS_B] & ~cs_prev_reg;
  assign selected = ~pin_f_reg[PIN_CS_B];

  // ==========================================================================
  // Instruction shifter
  logic [23:0] shift_reg;
  logic [5:0] bitcnt_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;

  // Bits enter on rising link clock edges, MSB first
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 24'h000000;
      bitcnt_reg <= 6'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end else if (cs_fall) begin
      bitcnt_reg <= 6'h00;
    end else if (selected && sclk_rise) begin
      shift_reg <= {shift_reg[22:0], pin_f_reg[PIN_DI]};
      if (bitcnt_reg != BITS_SAT) begin
        bitcnt_reg <= bitcnt_reg + 6'h01;
      end
      if (bitcnt_reg == BITS_OP_LAST) begin
        opcode_reg <= {shift_reg[6:0], pin_f_reg[PIN_DI]};
      end
      if (bitcnt_reg == BITS_ADDR_LAST) begin
        addr_reg <= {shift_reg[22:0], pin_f_reg[PIN_DI]};
      end
    end
  end

  // ==========================================================================
  // Status state
  fspr_state_e state_reg;
  fspr_nv_s nv_reg;
  logic loaded_reg;
  logic write_enable_latch_reg;
  logic suspend_flag_reg;
  logic [7:0] sr_lo;
  logic [7:0] sr_hi;

  // Status bytes as read back; S10 held at zero
  assign sr_lo = {nv_reg.status_protect_lo, nv_reg.sector_block_select,
                  nv_reg.top_bottom_select, nv_reg.range_bits, write_enable_latch_reg, busy_o};
  assign sr_hi = {suspend_flag_reg, nv_reg.complement_protect, nv_reg.security_lock, 1'b0,
                  nv_reg.quad_enable_bit, nv_reg.status_protect_hi};

  // Protected test for one address
  function automatic logic fspr_prot(input fspr_nv_s nv, input logic [ADDR_W-1:0] a);
    logic [21:0] size;
    logic [2:0] steps;
    logic hit;
    steps = (nv.range_bits > RANGE_SECT_MAX) ? RANGE_SECT_MAX : nv.range_bits;
    size = nv.sector_block_select ? (SECT_BYTES << (steps - 3'h1))
                                  : (BLK_BYTES << (nv.range_bits - 3'h1));
    if (nv.range_bits == 3'h0) begin
      hit = 1'b0;
    end else if (nv.range_bits[2:1] == 2'b11) begin
      hit = 1'b1;
    end else if (nv.top_bottom_select) begin
      hit = ({1'b0, a} < size);
    end else begin
      hit = ({1'b0, a} >= (FLASH_TOP - size));
    end
    return hit ^ nv.complement_protect;
  endfunction : fspr_prot

  // ==========================================================================
  // Instruction decode at deselect
  fspr_op_e kind;
  logic len_ok;
  logic blocked;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] a_lo;
  logic [ADDR_W-1:0] a_hi;
  logic [1:0] secr_idx;
  logic exec_en;
  logic sr_write_ok;
  logic acc_wren;
  logic acc_wrdi;
  logic acc_wrsr;
  logic acc_arr;
  logic acc_susp;
  logic acc_res;

  assign exec_en = cs_rise && (bitcnt_reg >= BITS_OP);
  assign a_lo = addr_reg[ADDR_W-1:0] & ~mask;
  assign a_hi = addr_reg[ADDR_W-1:0] | mask;
  assign secr_idx = addr_reg[SECR_IDX_LSB+1:SECR_IDX_LSB];

  // Kind, frame length and protection of array instructions
  always_comb begin
    kind = OP_NONE;
    len_ok = 1'b0;
    mask = '0;
    blocked = fspr_prot(nv_reg, a_lo) || fspr_prot(nv_reg, a_hi);
    case (opcode_reg)
      CMD_PROG: begin
        kind = OP_PROG;
        len_ok = bitcnt_reg >= BITS_PROG_MIN;
        mask = MASK_PAGE;
      end
      CMD_QPROG: begin
        kind = OP_QPROG;
        len_ok = (bitcnt_reg >= BITS_PROG_MIN) && nv_reg.quad_enable_bit;
        mask = MASK_PAGE;
      end
      CMD_SECT_ERASE: begin
        kind = OP_SECT_ERASE;
        len_ok = bitcnt_reg == BITS_ADDR;
        mask = MASK_SECT;
      end
      CMD_BLK32_ERASE: begin
        kind = OP_BLK32_ERASE;
        len_ok = bitcnt_reg == BITS_ADDR;
        mask = MASK_BLK32;
      end
      CMD_BLK64_ERASE: begin
        kind = OP_BLK64_ERASE;
        len_ok = bitcnt_reg == BITS_ADDR;
        mask = MASK_BLK64;
      end
      CMD_CHIP_ERASE: begin
        kind = OP_CHIP_ERASE;
        len_ok = bitcnt_reg == BITS_OP;
        mask = {ADDR_W{1'b1}};
      end
      CMD_SECR_ERASE, CMD_SECR_PROG: begin
        kind = (opcode_reg == CMD_SECR_ERASE) ? OP_SECR_ERASE : OP_SECR_PROG;
        len_ok = bitcnt_reg >= BITS_ADDR;
        blocked = (secr_idx == 2'h0) || nv_reg.security_lock[secr_idx - 2'h1];
      end
      default: begin
        kind = OP_NONE;
      end
    endcase
  end

  // Status write guard from protect mode, pin and quad mode
  always_comb begin
    case ({nv_reg.status_protect_hi, nv_reg.status_protect_lo})
      2'b00: sr_write_ok = 1'b1;
      2'b01: sr_write_ok = pin_f_reg[PIN_WP_B] || nv_reg.quad_enable_bit;
      default: sr_write_ok = 1'b0;
    endcase
  end

  // Busy refuses all but suspend and status reads
  assign acc_wren = exec_en && (state_reg == ST_IDLE) && (opcode_reg == CMD_WREN)
                    && (bitcnt_reg == BITS_OP);
  assign acc_wrdi = exec_en && (state_reg == ST_IDLE) && (opcode_reg == CMD_WRDI)
                    && (bitcnt_reg == BITS_OP);
  assign acc_wrsr = exec_en && (state_reg == ST_IDLE) && (opcode_reg == CMD_WRSR)
                    && write_enable_latch_reg
                    && ((bitcnt_reg == BITS_WRSR1) || (bitcnt_reg == BITS_WRSR2))
                    && sr_write_ok;
  assign acc_arr = exec_en && (state_reg == ST_IDLE) && write_enable_latch_reg
                   && (kind != OP_NONE) && len_ok && !blocked;
  assign acc_susp = exec_en && (state_reg == ST_BUSY) && (opcode_reg == CMD_SUSPEND)
                    && (op_o.kind != OP_SR_WRITE);
  assign acc_res = exec_en && (state_reg == ST_SUSP) && (opcode_reg == CMD_RESUME);

  // ==========================================================================
  // Operation state, busy flag and request to the array engine
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      busy_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (acc_wrsr || acc_arr) begin
            state_reg <= ST_BUSY;
            busy_o <= 1'b1;
          end
        end
        ST_BUSY: begin
          if (op_done_i) begin
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
          end else if (acc_susp) begin
            state_reg <= ST_SUSP;
            busy_o <= 1'b0;
          end
        end
        ST_SUSP: begin
          if (acc_res) begin
            state_reg <= ST_BUSY;
            busy_o <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // One-cycle request pulse; kind stays for the running operation
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_valid_o <= 1'b0;
      op_o <= '{kind: OP_NONE, addr: 24'h000000};
    end else begin
      op_valid_o <= acc_wrsr || acc_arr || acc_susp || acc_res;
      if (acc_wrsr) begin
        op_o <= '{kind: OP_SR_WRITE, addr: 24'h000000};
      end else if (acc_arr) begin
        op_o <= '{kind: kind, addr: addr_reg};
      end
    end
  end

  // Write enable latch
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch_reg <= 1'b0;
    end else if (acc_wren) begin
      write_enable_latch_reg <= 1'b1;
    end else if (acc_wrdi || ((state_reg == ST_BUSY) && op_done_i)) begin
      write_enable_latch_reg <= 1'b0;
    end
  end

  // Suspend flag, cleared by resume or power cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      suspend_flag_reg <= 1'b0;
    end else if (acc_susp) begin
      suspend_flag_reg <= 1'b1;
    end else if (acc_res) begin
      suspend_flag_reg <= 1'b0;
    end
  end

  // Non-volatile fields: image taken after release, then status writes
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      nv_reg <= '0;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      nv_reg <= nv_image_i;
      if ({nv_image_i.status_protect_hi, nv_image_i.status_protect_lo} == 2'b10) begin
        nv_reg.status_protect_hi <= 1'b0;
      end
    end else if (acc_wrsr) begin
      if (bitcnt_reg == BITS_WRSR2) begin
        nv_reg.status_protect_lo <= shift_reg[15];
        nv_reg.sector_block_select <= shift_reg[14];
        nv_reg.top_bottom_select <= shift_reg[13];
        nv_reg.range_bits <= shift_reg[12:10];
        nv_reg.complement_protect <= shift_reg[6];
        nv_reg.security_lock <= nv_reg.security_lock | shift_reg[5:3];
        nv_reg.quad_enable_bit <= shift_reg[1];
        nv_reg.status_protect_hi <= shift_reg[0];
      end else begin
        nv_reg.status_protect_lo <= shift_reg[7];
        nv_reg.sector_block_select <= shift_reg[6];
        nv_reg.top_bottom_select <= shift_reg[5];
        nv_reg.range_bits <= shift_reg[4:2];
      end
    end
  end

  assign nv_image_o = nv_reg;
  assign quad_lines_o = nv_reg.quad_enable_bit;

  // ==========================================================================
  // Status read-out on falling link clock edges
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      do_o <= 1'b0;
      do_oe_b_o <= 1'b1;
    end else if (!selected) begin
      do_oe_b_o <= 1'b1;
    end else if (sclk_fall && (bitcnt_reg >= BITS_OP)) begin
      if (opcode_reg == CMD_RDSR_LO) begin
        do_oe_b_o <= 1'b0;
        do_o <= sr_lo[BIT_MSB - bitcnt_reg[2:0]];
      end else if (opcode_reg == CMD_RDSR_HI) begin
        do_oe_b_o <= 1'b0;
        do_o <= sr_hi[BIT_MSB - bitcnt_reg[2:0]];
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  sequence seq_start;
    (state_reg == ST_IDLE) && (acc_wrsr || acc_arr);
  endsequence
  sequence seq_wrsr_locked;
    exec_en && (opcode_reg == CMD_WRSR) && loaded_reg
    && (nv_reg.status_protect_hi || (nv_reg.status_protect_lo && !pin_f_reg[PIN_WP_B]
    && !nv_reg.quad_enable_bit));
  endsequence

  AST_BUSY_SET: assert property (seq_start |=> busy_o && sr_lo[0])
    else $error("busy not raised on operation start");
  AST_BUSY_CLR: assert property ((state_reg == ST_BUSY) && op_done_i |=> !busy_o)
    else $error("busy not cleared at completion");
  AST_IGNORE: assert property (busy_o && exec_en && !op_done_i
    |=> $stable(write_enable_latch_reg) && $stable(nv_reg))
    else $error("instruction acted on while busy");
  AST_LATCH_SET: assert property (acc_wren |=> write_enable_latch_reg)
    else $error("write enable latch not set");
  AST_LATCH_CLR: assert property ((state_reg == ST_BUSY) && op_done_i
    |=> !write_enable_latch_reg)
    else $error("write enable latch kept after completion");
  AST_SR_LOCK: assert property (seq_wrsr_locked |=> $stable(nv_reg) [*2])
    else $error("locked status register was written");
  AST_LOCK_KEEP: assert property (loaded_reg |=> (nv_reg.security_lock
    & $past(nv_reg.security_lock)) == $past(nv_reg.security_lock))
    else $error("security lock bit cleared");
  AST_SUSPEND: assert property (acc_susp
    |=> suspend_flag_reg && !busy_o ##1 suspend_flag_reg)
    else $error("suspend flag not set");
  AST_PROT: assert property (exec_en && blocked && (kind != OP_NONE) |=> !op_valid_o)
    else $error("protected region operation started");
endmodule : fspr_status_protect

// [verification/fspr_host_model.sv]
/*
  Host SPI master model driving the flash status block pins in mode 0.
  Assumes one link bit spans 8 ref_clk cycles (320 ns) and inputs change
  at the falling ref_clk edge.
*/
`timescale 1ns/1ps
module fspr_host_model (
  input wire logic ref_clk_i,
  input wire logic do_i,
  input wire logic do_oe_b_i,
  output logic sclk_o,
  output logic cs_b_o,
  output logic di_o
);
  // ==========================================================================
  // Idle pins: clock low, device deselected
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    di_o = 1'b0;
  end

  // ==========================================================================
  // One frame; bits left aligned, seen holds the last 8 bits read back
  // Write-protect is driven by the bench, never strapped, so quad enable is safe
  task automatic frame(input logic [39:0] bits, input int n, output logic [7:0] seen);
    seen = 8'h00;
    @(negedge ref_clk_i);
    cs_b_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      di_o = bits[39 - i];
      repeat (4) @(negedge ref_clk_i);
      sclk_o = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      // Released line reads inverted, never a stale bit
      seen = {seen[6:0], do_oe_b_i ? ~do_i : do_i};
      @(negedge ref_clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge ref_clk_i);
    cs_b_o = 1'b1;
    di_o = ~di_o; // Released data line
    repeat (8) @(negedge ref_clk_i);
  endtask : frame
endmodule : fspr_host_model

// [verification/fspr_status_protect_test.sv]
/*
  Self-checking bench for the flash status and protection block.
  Assumes fspr_host_model for the SPI pins; the bench plays the array engine.
*/
`timescale 1ns/1ps
module fspr_status_protect_test;
  import fspr_pkg::*;
  logic ref_clk_i, rst_b_i, sclk_i, cs_b_i, di_i, wp_b_i, op_done_i;
  logic do_o, do_oe_b_o, busy_o, quad_lines_o, op_valid_o;
  fspr_nv_s nv_image_i, nv_image_o;
  fspr_op_s op_o;
  logic [7:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  int starts = 0;

  // ==========================================================================
  // Design and host
  fspr_status_protect DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i),
    .cs_b_i(cs_b_i), .di_i(di_i), .wp_b_i(wp_b_i), .nv_image_i(nv_image_i),
    .op_done_i(op_done_i), .do_o(do_o), .do_oe_b_o(do_oe_b_o), .busy_o(busy_o),
    .quad_lines_o(quad_lines_o), .nv_image_o(nv_image_o), .op_valid_o(op_valid_o),
    .op_o(op_o));
  fspr_host_model host (.ref_clk_i(ref_clk_i), .do_i(do_o), .do_oe_b_i(do_oe_b_o),
    .sclk_o(sclk_i), .cs_b_o(cs_b_i), .di_o(di_i));

  // Clock, 40 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Count request pulses to the array engine, suspend and resume included
  always @(posedge ref_clk_i) begin
    if (op_valid_o === 1'b1) starts++;
  end

  // ==========================================================================
  // Tasks
  task automatic complete_run();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op);
    host.frame({op, 32'h0}, 8, rd);
  endtask : cmd

  task automatic wrsr(input logic [15:0] v, input int n);
    host.frame({CMD_WRSR, v, 16'h0}, n, rd);
  endtask : wrsr

  task automatic status(input logic [7:0] op, input logic [7:0] exp);
    host.frame({op, 32'h0}, 16, rd);
    chk(op == CMD_RDSR_LO ? "status low" : "status high", {4'h0, rd}, {4'h0, exp});
  endtask : status

  // Array engine reports the running operation done
  task automatic finish_op();
    @(negedge ref_clk_i);
    op_done_i = 1'b1;
    @(negedge ref_clk_i);
    op_done_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask : finish_op

  // ==========================================================================
  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_b_i = 1'b0;
    wp_b_i = 1'b1;
    op_done_i = 1'b0;
    nv_image_i = 12'h041; // Lock-down mode, range 001
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    chk("nv image", nv_image_o, 12'h001);
    chk("quad lines", {11'h0, quad_lines_o}, 12'h000);
    status(CMD_RDSR_LO, 8'h04);
    status(CMD_RDSR_HI, 8'h00);
    wrsr(16'h1C00, 16);
    status(CMD_RDSR_LO, 8'h04);
    cmd(CMD_WREN);
    status(CMD_RDSR_LO, 8'h06);
    cmd(CMD_WRDI);
    status(CMD_RDSR_LO, 8'h04);
    cmd(CMD_WREN);
    wrsr(16'h9C4C, 24);
    chk("busy", {11'h0, busy_o}, 12'h001);
    status(CMD_RDSR_LO, 8'h9F);
    cmd(CMD_CHIP_ERASE);
    chk("starts", 12'(starts), 12'h001);
    finish_op();
    chk("busy", {11'h0, busy_o}, 12'h000);
    status(CMD_RDSR_LO, 8'h9C);
    status(CMD_RDSR_HI, 8'h48);
    chk("nv image", nv_image_o, 12'h927);
    // Hardware protected, then unprotected
    wp_b_i = 1'b0;
    cmd(CMD_WREN);
    wrsr(16'h0000, 16);
    status(CMD_RDSR_LO, 8'h9E);
    wp_b_i = 1'b1;
    wrsr(16'h8000, 16);
    finish_op();
    status(CMD_RDSR_LO, 8'h80);
    // Complement with empty range protects everything
    cmd(CMD_WREN);
    host.frame({CMD_PROG, 24'h000100, 8'hA5}, 40, rd);
    chk("starts", 12'(starts), 12'h002);
    status(CMD_RDSR_LO, 8'h82);
    wrsr(16'h8000, 24);
    finish_op();
    status(CMD_RDSR_HI, 8'h08);
    // Erase, suspend and resume
    cmd(CMD_WREN);
    host.frame({CMD_SECT_ERASE, 24'h000000, 8'h00}, 32, rd);
    chk("op kind", {8'h0, op_o.kind}, {8'h0, OP_SECT_ERASE});
    cmd(CMD_SUSPEND);
    chk("busy", {11'h0, busy_o}, 12'h000);
    status(CMD_RDSR_HI, 8'h88);
    cmd(CMD_RESUME);
    status(CMD_RDSR_HI, 8'h08);
    finish_op();
    status(CMD_RDSR_LO, 8'h80);
    // Lock-down mode refuses status writes
    cmd(CMD_WREN);
    wrsr(16'h0001, 24);
    finish_op();
    cmd(CMD_WREN);
    wrsr(16'h1C00, 16);
    status(CMD_RDSR_LO, 8'h02);
    // Power cycle while suspended clears suspend and lock-down
    cmd(CMD_WREN);
    cmd(CMD_CHIP_ERASE);
    cmd(CMD_SUSPEND);
    chk("starts", 12'(starts), 12'h009);
    rst_b_i = 1'b0;
    nv_image_i = 12'h15D; // Lock-down, lock 1, bottom sectors, range 101
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    chk("nv image", nv_image_o, 12'h11D);
    status(CMD_RDSR_HI, 8'h08);
    status(CMD_RDSR_LO, 8'h74);
    // Bottom 32KB protected in sector units
    cmd(CMD_WREN);
    host.frame({CMD_SECT_ERASE, 24'h007000, 8'h00}, 32, rd);
    host.frame({CMD_SECT_ERASE, 24'h008000, 8'h00}, 32, rd);
    chk("starts", 12'(starts), 12'h00A);
    chk("op addr", op_o.addr[23:12], 12'h008);
    finish_op();
    // Quad program needs the quad enable bit
    cmd(CMD_WREN);
    host.frame({CMD_QPROG, 24'h010000, 8'h00}, 40, rd);
    chk("starts", 12'(starts), 12'h00A);
    wrsr(16'h0002, 24);
    finish_op();
    chk("quad lines", {11'h0, quad_lines_o}, 12'h001);
    status(CMD_RDSR_HI, 8'h0A);
    cmd(CMD_WREN);
    host.frame({CMD_QPROG, 24'h010000, 8'h00}, 40, rd);
    chk("op kind", {8'h0, op_o.kind}, {8'h0, OP_QPROG});
    finish_op();
    // Locked security register refused, unlocked one accepted
    cmd(CMD_WREN);
    host.frame({CMD_SECR_PROG, 24'h001000, 8'hA5}, 40, rd);
    host.frame({CMD_SECR_PROG, 24'h002000, 8'hA5}, 40, rd);
    chk("starts", 12'(starts), 12'h00D);
    finish_op();
    status(CMD_RDSR_LO, 8'h00);
    complete_run();
  end
endmodule : fspr_status_protect_test
